/* design/rscl_pkg.sv */
// Shared constants of the remote status and control logic.
package rscl_pkg;
   // ==========================================================
   // Timing
   localparam int          CLK_HZ      = 200_000_000;
   localparam int          BAUD_RATE   = 300;
   localparam logic [19:0] BIT_CYC_DEF = 20'(CLK_HZ / BAUD_RATE);
   localparam int          WD_TIME_MS  = 2000;
   localparam logic [28:0] WD_CYC_DEF  = 29'(CLK_HZ / 1000 * WD_TIME_MS);
   // ==========================================================
   // Register offsets and reset values
   localparam logic [11:0] OFS_CTRL     = 12'h000;
   localparam logic [11:0] OFS_STATUS   = 12'h004;
   localparam logic [11:0] OFS_INT_STAT = 12'h008;
   localparam logic [11:0] OFS_INT_MASK = 12'h00c;
   localparam logic [1:0]  CTRL_RST     = 2'h0;
   localparam logic [3:0]  MASK_RST     = 4'h0;
   localparam logic [13:0] SYNC_RST     = 14'h00e1;
   // ==========================================================
   // Field positions
   localparam int CTRL_LMUTE_SAT = 0;
   localparam int CTRL_SMUTE_LOC = 1;
   localparam int STATUS_TO_BIT  = 16;
   localparam int INT_NEW        = 0;
   localparam int INT_TO         = 1;
   localparam int INT_PERR       = 2;
   localparam int INT_ALARM      = 3;
   localparam int ST_ALARM       = 0;
   localparam int ST_NORMAL      = 1;
   localparam int ST_WARN        = 2;
   localparam int ST_STBY        = 3;
   localparam int MSG_HEAD_BIT   = 7;
   localparam int SYNC_W         = 14;
endpackage : rscl_pkg

/* design/rscl_byte_if.sv */
// Byte stream carrier between the controller and its serial ports.
`timescale 1ns/1ps
interface rscl_byte_if;
   logic       valid;
   logic       ready;
   logic       perr;
   logic [7:0] data;
   modport src (output valid, output data, output perr, input ready);
   modport snk (input valid, input data, input perr, output ready);
endinterface : rscl_byte_if

/* design/rscl_uart_tx.sv */
// Serial byte transmitter with odd parity.
`timescale 1ns/1ps
module rscl_uart_tx
   import rscl_pkg::*;
#(
   parameter logic [19:0] BIT_CYC = BIT_CYC_DEF
)(
   input  wire logic clk_in,
   input  wire logic rstn_in,
   rscl_byte_if.snk  byte_in,
   output logic      txd_out
);
   typedef struct packed {
      logic        busy;
      logic [10:0] sh;
      logic [3:0]  n;
      logic [19:0] div;
   } rscl_tx_st_t;

   rscl_tx_st_t st;
   rscl_tx_st_t next_st;

   assign byte_in.ready = !st.busy;
   assign txd_out       = st.sh[0];

   always_comb
   begin
      next_st = st;
      if (!st.busy)
      begin
         if (byte_in.valid)
         begin
            next_st.busy = 1'b1;
            next_st.sh   = {1'b1, ~^byte_in.data, byte_in.data, 1'b0}; // see R2
            next_st.n    = 4'h0;
            next_st.div  = 20'h00000;
         end
      end
      else if (st.div == BIT_CYC - 20'h00001)
      begin
         next_st.div = 20'h00000;
         next_st.sh  = {1'b1, st.sh[10:1]};
         if (st.n == 4'ha)
            next_st.busy = 1'b0;
         else
            next_st.n = st.n + 4'h1;
      end
      else
         next_st.div = st.div + 20'h00001;
   end

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
         st <= '{busy: 1'b0, sh: 11'h7ff, n: 4'h0, div: 20'h00000};
      else
         st <= next_st;
   end

   property p_tx_start;
      @(posedge clk_in) disable iff (!rstn_in)
      $rose(st.busy) |-> !txd_out && st.sh[10];
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("frame lacks start or stop bit"); // see R2
endmodule : rscl_uart_tx

/* design/rscl_uart_rx.sv */
// Serial byte receiver with odd parity and stop bit check.
`timescale 1ns/1ps
module rscl_uart_rx
   import rscl_pkg::*;
#(
   parameter logic [19:0] BIT_CYC = BIT_CYC_DEF
)(
   input  wire logic clk_in,
   input  wire logic rstn_in,
   input  wire logic rxd_in,
   rscl_byte_if.src  byte_out
);
   typedef struct packed {
      logic        busy;
      logic [8:0]  sh;
      logic [3:0]  n;
      logic [19:0] div;
      logic        vld;
      logic        perr;
      logic [7:0]  data;
   } rscl_rx_st_t;

   rscl_rx_st_t st;
   rscl_rx_st_t next_st;
   logic [19:0] target;

   assign byte_out.valid = st.vld;
   assign byte_out.data  = st.data;
   assign byte_out.perr  = st.perr;
   assign target = (st.n == 4'h0) ? {1'b0, BIT_CYC[19:1]} : BIT_CYC - 20'h00001;

   always_comb
   begin
      next_st     = st;
      next_st.vld = 1'b0;
      if (!st.busy)
      begin
         if (!rxd_in)
         begin
            next_st.busy = 1'b1;
            next_st.n    = 4'h0;
            next_st.div  = 20'h00000;
         end
      end
      else if (st.div == target)
      begin
         next_st.div = 20'h00000;
         if (st.n == 4'h0 && rxd_in)
            next_st.busy = 1'b0;
         else if (st.n == 4'ha)
         begin
            next_st.busy = 1'b0;
            next_st.vld  = 1'b1;
            next_st.data = st.sh[7:0];
            next_st.perr = ~^st.sh | ~rxd_in; // see R2
         end
         else
         begin
            next_st.sh = {rxd_in, st.sh[8:1]};
            next_st.n  = st.n + 4'h1;
         end
      end
      else
         next_st.div = st.div + 20'h00001;
   end

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
         st <= '0;
      else
         st <= next_st;
   end

   property p_rx_pulse;
      @(posedge clk_in) disable iff (!rstn_in)
      st.vld |=> !st.vld;
   endproperty
   a_rx_pulse: assert property (p_rx_pulse) else $error("byte strobe longer than one cycle"); // see R3
endmodule : rscl_uart_rx

/* design/rscl_top.sv */
// Remote status and control logic: link, message check, lamps, sounders, APB registers.
// How it works
// R1 - Each command word leaves as two bytes.
// R2 - Bytes: start, eight data, odd parity, stop.
// R3 - Received bytes assemble into two-byte message.
// R4 - Accept only a message repeating the previous.
// R5 - Acceptance updates status and pulses new-message.
// R6 - Two seconds without acceptance or carrier: timeout.
// R7 - Timeout shows alarm lamp only.
// R8 - Mute key held lights all lamps, unless lockout is on.
// R9 - Lockout switches all lamps off.
// R10 - Normal-to-alarm change starts the sounders.
// R11 - Lamp test always sounds both sounders.
// R12 - Local mute key silences the local sounder.
// R13 - Two settings cross-couple the mute keys.
// R14 - Local and satellite requests merge into commands.
// R15 - Lamp, opto, satellite, sounder from accepted status.
// R16 - Inputs sampled and sent to the cabinet.
// R17 - Satellite requests are active low.
// R18 - Separate opto outputs for four status kinds.
// R19 - Next accepted message ends the forced alarm.
`timescale 1ns/1ps
module rscl_top
   import rscl_pkg::*;
#(
   parameter logic [19:0] BIT_CYC = BIT_CYC_DEF,
   parameter logic [28:0] WD_CYC  = WD_CYC_DEF
)(
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic             irq_out,
   input  wire logic        rxd_in,
   input  wire logic        carrier_in,
   output logic             txd_out,
   input  wire logic        mute_key_in,
   input  wire logic        onoff_key_in,
   input  wire logic        chg_key_in,
   input  wire logic        sat_onoff_n_in,
   input  wire logic        sat_chg_n_in,
   input  wire logic        sat_mute_n_in,
   input  wire logic        lockout_in,
   input  wire logic        tx_off_in,
   input  wire logic [3:0]  aux_in,
   output logic      [3:0]  lamp_out,
   output logic      [3:0]  opto_out,
   output logic      [3:0]  sat_lamp_out,
   output logic      [3:0]  sat_lamp_oe_out,
   output logic             buzzer_out,
   output logic             sat_buzzer_out,
   output logic             sat_buzzer_oe_out,
   output logic             new_msg_out,
   output logic      [15:0] status_out,
   output logic             timeout_out
);
   // ==========================================================
   // State
   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic              half;
      logic [7:0]        b0;
      logic              have_prev;
      logic [15:0]       prev;
      logic [15:0]       stat;
      logic              newp;
      logic [28:0]       wd;
      logic              to;
      logic              was_norm;
      logic              lbuz;
      logic              sbuz;
      logic              tb;
      logic [1:0]        cfg;
      logic [3:0]        ist;
      logic [3:0]        imask;
      logic [31:0]       rdata;
      logic              slverr;
      logic [3:0]        lamp;
      logic [3:0]        opto;
      logic [3:0]        slamp;
      logic              lbz_o;
      logic              sbz_o;
      logic              irq;
   } rscl_st_t;

   rscl_st_t    st;
   rscl_st_t    next_st;
   rscl_byte_if rx_bus ();
   rscl_byte_if tx_bus ();

   logic        rxd_s;
   logic        cd;
   logic        lmute;
   logic        smute;
   logic        lt;
   logic        lock;
   logic        onoff_req;
   logic        chg_req;
   logic        txoff;
   logic [3:0]  aux;
   logic [15:0] msg;
   logic        msg_done;
   logic        acc;
   logic        trans;
   logic [3:0]  eff;
   logic [3:0]  ev;
   logic [3:0]  w1c;
   logic        wr;
   logic        clr_l;
   logic        clr_s;

   function automatic logic addr_hit(input logic [11:0] a);
      addr_hit = (a == OFS_CTRL) || (a == OFS_STATUS) ||
                 (a == OFS_INT_STAT) || (a == OFS_INT_MASK);
   endfunction : addr_hit

   // ==========================================================
   // Serial ports
   rscl_uart_rx #(.BIT_CYC(BIT_CYC)) u_rx (
      .clk_in   (clk_in),
      .rstn_in  (rstn_in),
      .rxd_in   (rxd_s),
      .byte_out (rx_bus)
   );

   rscl_uart_tx #(.BIT_CYC(BIT_CYC)) u_tx (
      .clk_in  (clk_in),
      .rstn_in (rstn_in),
      .byte_in (tx_bus),
      .txd_out (txd_out)
   );

   // ==========================================================
   // Synchronised pins and merged requests
   // Only the second synchroniser stage is read, so a pin edge cannot split decisions.
   assign rxd_s     = st.s2[0];
   assign cd        = st.s2[1];
   assign lmute     = st.s2[2];
   assign smute     = ~st.s2[7];                       // see R17
   assign lock      = st.s2[8];
   assign txoff     = st.s2[9];
   assign aux       = st.s2[13:10];
   assign onoff_req = st.s2[3] | ~st.s2[5];            // see R14, R17
   assign chg_req   = st.s2[4] | ~st.s2[6];            // see R14, R17
   assign lt        = lmute | smute;

   // The transmitter is always fed, so the cabinet sees the inputs continuously.
   assign rx_bus.ready = 1'b1;
   assign tx_bus.valid = 1'b1;
   assign tx_bus.perr  = 1'b0;
   assign tx_bus.data  = st.tb ? {4'h0, aux} :
                         {1'b1, 2'h0, txoff, lock, lt, chg_req, onoff_req}; // see R1, R16

   // ==========================================================
   // Message assembly and check
   assign msg      = {st.b0, rx_bus.data};
   assign msg_done = rx_bus.valid && !rx_bus.perr && st.half &&
                     !rx_bus.data[MSG_HEAD_BIT];                             // see R3
   assign acc      = msg_done && st.have_prev && (msg == st.prev) && cd;    // see R4
   assign eff      = st.to ? (4'h1 << ST_ALARM) : st.stat[3:0];            // see R7
   assign trans    = st.was_norm && eff[ST_ALARM];                          // see R10
   assign wr       = psel_in && penable_in && pwrite_in;
   assign w1c      = (wr && paddr_in == OFS_INT_STAT) ? pwdata_in[3:0] : 4'h0;
   assign clr_l    = lmute || (st.cfg[CTRL_SMUTE_LOC] && smute);           // see R12, R13
   assign clr_s    = smute || (st.cfg[CTRL_LMUTE_SAT] && lmute);           // see R13

   always_comb
   begin
      next_st      = st;
      next_st.s1   = {aux_in, tx_off_in, lockout_in, sat_mute_n_in, sat_chg_n_in,
                      sat_onoff_n_in, chg_key_in, onoff_key_in, mute_key_in,
                      carrier_in, rxd_in};
      next_st.s2   = st.s1;
      next_st.newp = 1'b0;
      ev           = 4'h0;

      if (tx_bus.ready)
         next_st.tb = ~st.tb;                                                // see R1

      if (rx_bus.valid)
      begin
         if (rx_bus.perr)
         begin
            next_st.half    = 1'b0;
            ev[INT_PERR]    = 1'b1;
         end
         else if (rx_bus.data[MSG_HEAD_BIT])
         begin
            next_st.b0   = rx_bus.data;
            next_st.half = 1'b1;
         end
         else if (st.half)
         begin
            next_st.half      = 1'b0;
            next_st.prev      = msg;
            next_st.have_prev = 1'b1;
         end
      end

      if (acc)
      begin
         next_st.stat = msg;                                                 // see R5
         next_st.newp = 1'b1;                                                // see R5
         next_st.wd   = 29'h0;                                               // see R19
      end
      else if (st.wd != WD_CYC)
         next_st.wd = st.wd + 29'h1;                                         // see R6
      next_st.to = (next_st.wd == WD_CYC);                                   // see R6

      next_st.was_norm = eff[ST_NORMAL];
      next_st.lbuz     = trans | (st.lbuz & ~clr_l);                         // see R10, R12
      next_st.sbuz     = trans | (st.sbuz & ~clr_s);                         // see R10, R13
      next_st.lbz_o    = next_st.lbuz | lt;                                  // see R11
      next_st.sbz_o    = next_st.sbuz | lt;                                  // see R11

      if (lock)
         next_st.lamp = 4'h0;                                                // see R9
      else if (lt)
         next_st.lamp = 4'hf;                                                // see R8
      else
         next_st.lamp = eff;                                                 // see R15
      next_st.slamp = next_st.lamp;                                          // see R15
      next_st.opto  = eff;                                                   // see R18

      ev[INT_NEW]   = acc;
      ev[INT_TO]    = next_st.to && !st.to;
      ev[INT_ALARM] = trans;
      // A new event wins over a software clear in the same cycle.
      next_st.ist   = ev | (st.ist & ~w1c);
      next_st.irq   = |(next_st.ist & st.imask);

      if (wr && paddr_in == OFS_CTRL)
         next_st.cfg = pwdata_in[1:0];
      if (wr && paddr_in == OFS_INT_MASK)
         next_st.imask = pwdata_in[3:0];

      if (psel_in && !penable_in)
      begin
         next_st.slverr = !addr_hit(paddr_in);
         unique case (paddr_in)
            OFS_CTRL:     next_st.rdata = {30'h0, st.cfg};
            OFS_STATUS:   next_st.rdata = {15'h0, st.to, st.stat};
            OFS_INT_STAT: next_st.rdata = {28'h0, st.ist};
            OFS_INT_MASK: next_st.rdata = {28'h0, st.imask};
            default:      next_st.rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (!rstn_in)
      begin
         st       <= '0;
         st.s1    <= SYNC_RST;
         st.s2    <= SYNC_RST;
         st.cfg   <= CTRL_RST;
         st.imask <= MASK_RST;
      end
      else
         st <= next_st;
   end

   // ==========================================================
   // Outputs
   assign prdata_out        = st.rdata;
   assign pready_out        = 1'b1;
   assign pslverr_out       = st.slverr;
   assign irq_out           = st.irq;
   assign lamp_out          = st.lamp;
   assign opto_out          = st.opto;
   assign sat_lamp_out      = 4'h0;
   assign sat_lamp_oe_out   = st.slamp;
   assign buzzer_out        = st.lbz_o;
   assign sat_buzzer_out    = 1'b0;
   assign sat_buzzer_oe_out = st.sbz_o;
   assign new_msg_out       = st.newp;
   assign status_out        = st.stat;
   assign timeout_out       = st.to;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!rstn_in);

   property p_accept;
      st.newp |-> st.stat == st.prev && st.have_prev;
   endproperty
   a_accept: assert property (p_accept) else $error("message taken without repeat"); // see R4

   property p_pulse;
      st.newp |=> !st.newp;
   endproperty
   a_pulse: assert property (p_pulse) else $error("new-message pulse too long"); // see R5

   property p_timeout;
      st.to |-> st.wd == WD_CYC;
   endproperty
   a_timeout: assert property (p_timeout) else $error("timeout before full count"); // see R6

   property p_to_lamp;
      st.to && !lock && !lt |=> st.lamp == 4'h1 && st.opto == 4'h1;
   endproperty
   a_to_lamp: assert property (p_to_lamp) else $error("timeout not shown as alarm"); // see R7

   property p_lamptest;
      lt && !lock |=> st.lamp == 4'hf;
   endproperty
   a_lamptest: assert property (p_lamptest) else $error("lamp test not all lit"); // see R8

   property p_lockout;
      lock |=> st.lamp == 4'h0 && st.slamp == 4'h0;
   endproperty
   a_lockout: assert property (p_lockout) else $error("lamps lit under lockout"); // see R9

   sequence s_alarm_edge;
      st.was_norm && eff[ST_ALARM];
   endsequence
   property p_buz_on;
      s_alarm_edge |=> st.lbuz && st.sbuz ##1 st.lbz_o;
   endproperty
   a_buz_on: assert property (p_buz_on) else $error("sounders silent on alarm"); // see R10

   property p_lt_buz;
      lt |=> st.lbz_o && st.sbz_o;
   endproperty
   a_lt_buz: assert property (p_lt_buz) else $error("lamp test without sounders"); // see R11

   property p_mute;
      lmute && !trans |=> !st.lbuz;
   endproperty
   a_mute: assert property (p_mute) else $error("local mute failed"); // see R12

   property p_resume;
      st.newp |-> !st.to;
   endproperty
   a_resume: assert property (p_resume) else $error("timeout kept after acceptance"); // see R19
endmodule : rscl_top

/* verif/rscl_cab_model.sv */
// Cabinet side model: sends status messages and decodes command bytes.
`timescale 1ns/1ps
module rscl_cab_model #(
   parameter int BC = 16
)(
   input  wire logic        clk_in,
   input  wire logic        go_in,
   input  wire logic        bad_in,
   input  wire logic [15:0] msg_in,
   input  wire logic        txd_in,
   output logic             rxd_out,
   output logic             busy_out,
   output logic      [7:0]  head_out,
   output logic      [7:0]  tail_out
);
   logic [7:0] b;
   initial rxd_out = 1'b1;
   initial busy_out = 1'b0;
   initial head_out = 8'h00;
   initial tail_out = 8'h00;
   // ==========================================================
   // Sender
   // A bad request inverts the parity bit so the frame must be dropped.
   task automatic send(input logic [7:0] d);
      logic [10:0] f;
      f = {1'b1, ~^d ^ bad_in, d, 1'b0};
      for (int i = 0; i < 11; i++)
      begin
         rxd_out <= f[i];
         repeat (BC) @(posedge clk_in);
      end
   endtask : send
   always
   begin
      @(posedge clk_in);
      if (go_in)
      begin
         busy_out <= 1'b1;
         send(msg_in[15:8]);
         send(msg_in[7:0]);
         busy_out <= 1'b0;
      end
   end
   // ==========================================================
   // Receiver
   // Bytes with a bad parity or stop bit are dropped.
   always
   begin
      @(negedge txd_in);
      repeat (BC / 2) @(posedge clk_in);
      for (int i = 0; i < 8; i++)
      begin
         repeat (BC) @(posedge clk_in);
         b[i] = txd_in;
      end
      repeat (BC) @(posedge clk_in);
      if (txd_in === ~^b)
      begin
         repeat (BC) @(posedge clk_in);
         if (txd_in === 1'b1 && b[7])
            head_out <= b;
         if (txd_in === 1'b1 && !b[7])
            tail_out <= b;
      end
   end
endmodule : rscl_cab_model

/* verif/rscl_top_test.sv */
// Self-checking bench of the remote status and control logic.
`timescale 1ns/1ps
module rscl_top_test;
   import rscl_pkg::*;
   localparam int BC = 16;
   localparam int WD = 4000;
   logic        clk_in = 1'b0;
   logic        rstn_in = 1'b0;
   logic        psel_in, penable_in, pwrite_in, pready_out, pslverr_out, irq_out;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd;
   logic        rxd_in, carrier_in, txd_out, mute_key_in, onoff_key_in, chg_key_in;
   logic        sat_onoff_n_in, sat_chg_n_in, sat_mute_n_in, lockout_in, tx_off_in;
   logic [3:0]  aux_in, lamp_out, opto_out, sat_lamp_out, sat_lamp_oe_out;
   logic        buzzer_out, sat_buzzer_out, sat_buzzer_oe_out, new_msg_out, timeout_out;
   logic [15:0] status_out, msg, m;
   logic        go, bad, busy, er;
   logic [7:0]  head, tail;
   int          errors = 0;
   int          compares = 0;
   int          nm = 0;
   int          n0;

   always #2.5 clk_in = ~clk_in;
   always @(posedge clk_in)
      if (new_msg_out === 1'b1)
         nm <= nm + 1;

   rscl_top #(.BIT_CYC(20'd16), .WD_CYC(29'd4000)) u_rscl_top (
      .clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
      .prdata_out, .pready_out, .pslverr_out, .irq_out, .rxd_in, .carrier_in, .txd_out,
      .mute_key_in, .onoff_key_in, .chg_key_in, .sat_onoff_n_in, .sat_chg_n_in,
      .sat_mute_n_in, .lockout_in, .tx_off_in, .aux_in, .lamp_out, .opto_out,
      .sat_lamp_out, .sat_lamp_oe_out, .buzzer_out, .sat_buzzer_out,
      .sat_buzzer_oe_out, .new_msg_out, .status_out, .timeout_out
   );
   rscl_cab_model #(.BC(BC)) u_rscl_cab_model (
      .clk_in, .go_in(go), .bad_in(bad), .msg_in(msg), .txd_in(txd_out),
      .rxd_out(rxd_in), .busy_out(busy), .head_out(head), .tail_out(tail)
   );

   // ==========================================================
   // Helpers
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string s);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value at %0t ns: %s got %h expected %h", $time, s, g, e);
      end
   endtask : chk

   task automatic conclude();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : conclude

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do
         @(posedge clk_in);
      while (pready_out !== 1'b1);
      rd = prdata_out;
      er = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb

   task automatic send(input logic [15:0] v, input logic b);
      @(posedge clk_in);
      msg <= v;
      bad <= b;
      go <= 1'b1;
      @(posedge clk_in);
      go <= 1'b0;
      @(posedge clk_in);
      while (busy === 1'b1)
         @(posedge clk_in);
      repeat (6) @(posedge clk_in);
   endtask : send

   task automatic accept(input logic [15:0] v);
      int k;
      k = nm;
      send(v, 1'b0);
      chk(nm, k, "single message taken");
      send(v, 1'b0);
      chk(nm, k + 1, "new message pulses");
      chk(status_out, v, "held status");
   endtask : accept

   function automatic logic [3:0] exp_lamp(logic [3:0] st, logic to, logic lt, logic lk);
      if (lk)
         return 4'h0;
      if (lt)
         return 4'hf;
      if (to)
         return 4'h1;
      return st;
   endfunction : exp_lamp

   function automatic logic [7:0] exp_head();
      return {3'h4, tx_off_in, lockout_in, mute_key_in | ~sat_mute_n_in,
              chg_key_in | ~sat_chg_n_in, onoff_key_in | ~sat_onoff_n_in};
   endfunction : exp_head

   task automatic lamps(input logic [3:0] st, input logic to, input logic lk);
      chk(lamp_out, exp_lamp(st, to, 1'b0, lk), "lamps");
      chk(sat_lamp_oe_out, exp_lamp(st, to, 1'b0, lk), "satellite lamps");
      chk(opto_out, exp_lamp(st, to, 1'b0, 1'b0), "opto");
      chk({sat_buzzer_out, sat_lamp_out}, 5'h0, "satellite levels");
   endtask : lamps

   // Holding either mute key is a lamp test, so sounders are judged after release.
   task automatic tap(input logic sat);
      @(posedge clk_in);
      mute_key_in <= ~sat;
      sat_mute_n_in <= ~sat;
      repeat (8) @(posedge clk_in);
      chk(lamp_out, 4'hf, "lamp test");
      chk({buzzer_out, sat_buzzer_oe_out}, 2'h3, "lamp test sounders");
      mute_key_in <= 1'b0;
      sat_mute_n_in <= 1'b1;
      repeat (8) @(posedge clk_in);
   endtask : tap

   // ==========================================================
   // Watchdog
   initial
   begin
      repeat (40000) @(posedge clk_in);
      errors++;
      conclude();
   end

   // ==========================================================
   // Tests
   initial
   begin
      {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in, go, bad, msg} = '0;
      {mute_key_in, onoff_key_in, chg_key_in, lockout_in, tx_off_in, aux_in} = '0;
      {carrier_in, sat_onoff_n_in, sat_chg_n_in, sat_mute_n_in} = 4'hf;
      void'($urandom(32'h2df6));
      repeat (16) @(posedge clk_in);
      rstn_in <= 1'b1;
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, {30'h0, CTRL_RST}, "control reset");
      apb(1'b0, OFS_INT_MASK, 32'h0);
      chk(rd, {28'h0, MASK_RST}, "mask reset");
      apb(1'b1, 12'h010, 32'hffffffff);
      chk(er, 1'b1, "unmapped error");
      apb(1'b1, OFS_STATUS, 32'hffffffff);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd, 32'h0, "status read only");
      apb(1'b1, OFS_INT_MASK, 32'h2);
      $display("registers test done");
      repeat (WD) @(posedge clk_in);
      chk(timeout_out, 1'b1, "link timeout");
      lamps(4'h0, 1'b1, 1'b0);
      chk(irq_out, 1'b1, "timeout interrupt");
      apb(1'b1, OFS_INT_STAT, 32'hf);
      repeat (2) @(posedge clk_in);
      chk(irq_out, 1'b0, "interrupt cleared");
      accept(16'h8102);
      lamps(4'h2, 1'b0, 1'b0);
      chk(timeout_out, 1'b0, "timeout ends");
      $display("timeout test done");
      n0 = nm;
      send(16'h8304, 1'b0);
      send(16'h8308, 1'b0);
      send(16'h8502, 1'b1);
      send(16'h8502, 1'b0);
      chk(nm, n0, "differing or broken pairs");
      apb(1'b0, OFS_INT_STAT, 32'h0);
      chk(rd[INT_PERR], 1'b1, "parity event");
      carrier_in <= 1'b0;
      send(16'h8604, 1'b0);
      send(16'h8604, 1'b0);
      carrier_in <= 1'b1;
      chk(nm, n0, "no carrier");
      chk(status_out, 16'h8102, "status kept");
      $display("filter test done");
      for (int i = 0; i < 3; i++)
      begin
         m = {1'b1, 7'($urandom), 1'b0, 7'($urandom)};
         accept(m);
         lamps(m[3:0], 1'b0, 1'b0);
      end
      $display("status test done");
      apb(1'b1, OFS_CTRL, 32'h3);
      accept(16'h8002);
      tap(1'b0);
      chk({buzzer_out, sat_buzzer_oe_out}, 2'h0, "both muted");
      apb(1'b1, OFS_CTRL, 32'h0);
      accept(16'h8001);
      chk({buzzer_out, sat_buzzer_oe_out}, 2'h3, "alarm sounds");
      tap(1'b0);
      chk({buzzer_out, sat_buzzer_oe_out}, 2'h1, "local muted");
      apb(1'b1, OFS_CTRL, 32'h1);
      tap(1'b0);
      chk(sat_buzzer_oe_out, 1'b0, "satellite muted");
      accept(16'h8002);
      accept(16'h8001);
      apb(1'b1, OFS_CTRL, 32'h2);
      tap(1'b1);
      chk(buzzer_out, 1'b0, "satellite key mutes local");
      $display("sounder test done");
      for (int i = 0; i < 3; i++)
      begin
         @(posedge clk_in);
         onoff_key_in <= 1'($urandom);
         chg_key_in <= 1'($urandom);
         sat_onoff_n_in <= 1'($urandom);
         sat_chg_n_in <= 1'($urandom);
         tx_off_in <= 1'($urandom);
         lockout_in <= (i == 0) ? 1'b1 : 1'($urandom);
         aux_in <= 4'($urandom);
         repeat (800) @(posedge clk_in);
         chk(head, exp_head(), "command head");
         chk(tail, {4'h0, aux_in}, "command tail");
         lamps(4'h1, 1'b0, lockout_in);
      end
      lockout_in <= 1'b0;
      $display("command test done");
      apb(1'b1, OFS_INT_MASK, 32'h0);
      apb(1'b1, OFS_INT_STAT, 32'hf);
      accept(16'h8002);
      chk(irq_out, 1'b0, "masked event");
      apb(1'b0, OFS_INT_STAT, 32'h0);
      chk(rd[INT_NEW], 1'b1, "new message event");
      apb(1'b1, OFS_INT_MASK, 32'h1);
      repeat (2) @(posedge clk_in);
      chk(irq_out, 1'b1, "unmasked event");
      apb(1'b1, OFS_INT_STAT, 32'h1);
      repeat (2) @(posedge clk_in);
      chk(irq_out, 1'b0, "event cleared");
      $display("interrupt test done");
      conclude();
   end
endmodule : rscl_top_test
